/* File: pkg/plr_pkg.sv */
package plr_pkg;
  // Behaviour
  // - Point covers pixels with centers inside size-wide square
  // - Program size is clamped when enabled, else stored size
  // - Point size resets to 1.0; nonpositive writes flag error
  // - With fade and multisample, width is max(size,thr), fade (size/thr)^2
  // - Negative fade threshold writes flag error, keep value
  // - Sprite origin bit resets to upper-left
  // - Point fragments carry the point vertex data
  // - s is half plus x offset over size
  // - t adds or subtracts y offset per origin
  // - Sprite r and q are constants zero and one
  // - Unsupported sizes snap to nearest supported, 1.0 kept
  // - Multisample point emits pixels with any covered sample
  // - Line width resets to 1.0; nonpositive writes flag error
  // - Slope within [-1,1] means x-major
  // - Fragments follow diamond-exit crossing of the segment
  // - Boundary ties break as if shifted by epsilon
  // - Segments are half-open, end fragment not drawn
  // - One fragment per major column, within one unit
  // - Joined segments give no duplicate and no gap
  // - Line data uses projected t, perspective corrected
  // - Line depth is linear in t
  // - Noperspective linear, flat takes provoking vertex
  // - Single-sample mode sets full coverage

  typedef logic signed [15:0] plr_q_t;

  localparam int PLR_NATTR   = 2;
  localparam int PLR_AW      = 16 * PLR_NATTR;
  localparam int PLR_SAMPLES = 4;
  localparam int PLR_TSH     = 12;

  localparam logic [12:0] PLR_T_ONE   = 13'h1000;
  localparam plr_q_t      PLR_ST_HALF = 16'sh0080;
  localparam plr_q_t      PLR_ST_ONE  = 16'sh0100;
  localparam logic [8:0]  PLR_FADE_1  = 9'h100;
  localparam logic [3:0]  PLR_CENTER  = 4'h8;
  localparam logic [3:0]  PLR_SAMP_X [PLR_SAMPLES] =
    '{4'h6, 4'he, 4'h2, 4'ha};
  localparam logic [3:0]  PLR_SAMP_Y [PLR_SAMPLES] =
    '{4'h2, 4'h6, 4'ha, 4'he};

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] PLR_REG_CTRL   = 8'h00;
  localparam logic [7:0] PLR_REG_PSIZE  = 8'h04;
  localparam logic [7:0] PLR_REG_LWIDTH = 8'h08;
  localparam logic [7:0] PLR_REG_FTHR   = 8'h0c;
  localparam logic [7:0] PLR_REG_ERR    = 8'h10;
  localparam logic [7:0] PLR_REG_STATUS = 8'h14;

  localparam int PLR_CTRL_PROG   = 0;
  localparam int PLR_CTRL_MS     = 1;
  localparam int PLR_CTRL_ORIGIN = 2;
  localparam int PLR_CTRL_FADE   = 3;
  localparam int PLR_CTRL_MODE   = 8;
  localparam logic [31:0] PLR_CTRL_MASK = 32'h0000_000f |
    (((32'h1 << (2 * PLR_NATTR)) - 32'h1) << PLR_CTRL_MODE);
  localparam logic [31:0] PLR_CTRL_RST  = 32'h0000_0004;

  localparam plr_q_t PLR_SIZE_ONE = 16'sh0010;
  localparam plr_q_t PLR_PSIZE_RST = PLR_SIZE_ONE;
  localparam plr_q_t PLR_LWIDTH_RST = PLR_SIZE_ONE;
  localparam plr_q_t PLR_FTHR_RST = PLR_SIZE_ONE;

  localparam logic [1:0] PLR_MODE_NOPERSP = 2'h1;
  localparam logic [1:0] PLR_MODE_FLAT    = 2'h2;

  typedef struct packed {
    logic              is_line;
    plr_q_t            xa;
    plr_q_t            ya;
    logic [15:0]       za;
    logic [15:0]       wa;
    logic [PLR_AW-1:0] fa;
    plr_q_t            xb;
    plr_q_t            yb;
    logic [15:0]       zb;
    logic [15:0]       wb;
    logic [PLR_AW-1:0] fb;
    plr_q_t            shader_size_output;
  } plr_prim_s;

  typedef struct packed {
    plr_q_t                 x;
    plr_q_t                 y;
    logic [15:0]            z;
    logic [PLR_AW-1:0]      attr;
    plr_q_t                 s;
    plr_q_t                 t;
    plr_q_t                 r;
    plr_q_t                 q;
    logic [PLR_SAMPLES-1:0] cov;
    logic [8:0]             fade;
    logic                   is_line;
  } plr_frag_s;
endpackage

/* File: rtl/plr_top.sv */
`timescale 1ns/100ps
module plr_top #(
  parameter logic signed [15:0] SIZE_MAX  = 16'sh0400,
  parameter logic signed [15:0] SIZE_GRAN = 16'sh0004
) (
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [31:0]        wb_dat_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic               wb_we_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  output      logic [31:0]        wb_dat_o,
  output      logic               wb_ack_o,
  input  wire logic               prim_valid,
  output      logic               prim_ready,
  input  wire plr_pkg::plr_prim_s prim,
  output      logic               frag_valid,
  input  wire logic               frag_ready,
  output      plr_pkg::plr_frag_s frag
);
  import plr_pkg::*;

  if (SIZE_GRAN <= 0 || SIZE_MAX < PLR_SIZE_ONE ||
      (SIZE_MAX % SIZE_GRAN) != 0 ||
      (PLR_SIZE_ONE % SIZE_GRAN) != 0)
  begin : g_bad_size
    $error("plr_top: point size range not servable");
  end

  typedef enum logic [1:0] {
    ST_IDLE, ST_SETUP, ST_POINT, ST_LINE
  } plr_st_e;

  plr_st_e     st;
  logic [31:0] ctrl;
  plr_q_t      point_size;
  plr_q_t      line_width;
  plr_q_t      fade_thr;
  logic        err;
  logic [15:0] frag_cnt;
  plr_prim_s   pr;
  plr_q_t      w;
  logic [8:0]  fade;
  plr_q_t      bx0;
  plr_q_t      bx1;
  plr_q_t      by1;
  plr_q_t      cx;
  plr_q_t      cy;
  plr_q_t      c;
  plr_q_t      ce;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic plr_q_t to_q(input plr_q_t p,
                                  input logic [3:0] f);
    return {p[11:0], f};
  endfunction

  function automatic plr_q_t snap(input plr_q_t v);
    int k;
    k = int'(v);
    if (k < int'(SIZE_GRAN))
      k = int'(SIZE_GRAN);
    if (k > int'(SIZE_MAX))
      k = int'(SIZE_MAX);
    k = ((k + int'(SIZE_GRAN) / 2) / int'(SIZE_GRAN))
        * int'(SIZE_GRAN);
    return plr_q_t'(k);
  endfunction

  function automatic plr_q_t sprite(input plr_q_t p,
    input plr_q_t ctr, input plr_q_t sz, input logic neg);
    logic signed [31:0] d;
    d = ((32'(to_q(p, PLR_CENTER)) - 32'(ctr)) <<< 8) / 32'(sz);
    return neg ? plr_q_t'(32'(PLR_ST_HALF) - d)
               : plr_q_t'(32'(PLR_ST_HALF) + d);
  endfunction

  function automatic logic [PLR_SAMPLES-1:0] samp_cov(
    input plr_q_t px, input plr_q_t py, input plr_q_t xw,
    input plr_q_t yw, input plr_q_t sz, input logic ms);
    logic signed [17:0] ox;
    logic signed [17:0] oy;
    logic [PLR_SAMPLES-1:0] k;
    k = '0;
    for (int i = 0; i < PLR_SAMPLES; i++)
    begin
      ox = (18'(to_q(px, ms ? PLR_SAMP_X[i] : PLR_CENTER))
            - 18'(xw)) <<< 1;
      oy = (18'(to_q(py, ms ? PLR_SAMP_Y[i] : PLR_CENTER))
            - 18'(yw)) <<< 1;
      k[i] = ox >= -18'(sz) && ox < 18'(sz) &&
             oy >= -18'(sz) && oy < 18'(sz);
    end
    if (!ms)
      k = {PLR_SAMPLES{k[0]}};
    return k;
  endfunction

  function automatic logic [15:0] interp(input logic [1:0] m,
    input logic signed [31:0] a, input logic signed [31:0] b,
    input logic signed [31:0] wa, input logic signed [31:0] wb,
    input logic [12:0] t);
    logic signed [63:0] ta;
    logic signed [63:0] tb;
    logic signed [63:0] num;
    logic signed [63:0] den;
    ta = 64'(PLR_T_ONE) - 64'(t);
    tb = 64'(t);
    num = ta * 64'(a) * 64'(wb) + tb * 64'(b) * 64'(wa);
    den = ta * 64'(wb) + tb * 64'(wa);
    if (m == PLR_MODE_FLAT)
      return b[15:0];
    if (m == PLR_MODE_NOPERSP || den == 0)
      return 16'((ta * 64'(a) + tb * 64'(b)) >>> PLR_TSH);
    return 16'(num / den);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o,
    input logic [31:0] n, input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      if (s[i])
        o[8*i +: 8] = n[8*i +: 8];
    return o;
  endfunction

  // ------------------------------------------------------------
  // Wishbone slave
  // ------------------------------------------------------------
  logic        wb_req;
  logic        wb_wr;
  logic [31:0] m_ps;
  logic [31:0] m_lw;
  logic [31:0] m_ft;
  logic [31:0] rd;
  logic        reject;
  logic        err_clr;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Write lands on the edge that ends ack
  assign wb_wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign m_ps = merge({16'h0000, point_size}, wb_dat_i, wb_sel_i);
  assign m_lw = merge({16'h0000, line_width}, wb_dat_i, wb_sel_i);
  assign m_ft = merge({16'h0000, fade_thr}, wb_dat_i, wb_sel_i);
  assign reject = wb_wr &&
    ((wb_adr_i == PLR_REG_PSIZE && $signed(m_ps[15:0]) <= 0) ||
     (wb_adr_i == PLR_REG_LWIDTH && $signed(m_lw[15:0]) <= 0) ||
     (wb_adr_i == PLR_REG_FTHR && $signed(m_ft[15:0]) < 0));
  assign err_clr = wb_wr && wb_adr_i == PLR_REG_ERR &&
                   wb_sel_i[0] && wb_dat_i[0];

  always_comb
  begin
    case (wb_adr_i)
      PLR_REG_CTRL:   rd = ctrl;
      PLR_REG_PSIZE:  rd = {16'h0000, point_size};
      PLR_REG_LWIDTH: rd = {16'h0000, line_width};
      PLR_REG_FTHR:   rd = {16'h0000, fade_thr};
      PLR_REG_ERR:    rd = {31'h0000_0000, err};
      PLR_REG_STATUS:
        rd = {frag_cnt, 14'h0000, frag_valid, st != ST_IDLE};
      default:        rd = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? rd : 32'h0000_0000;
    end

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      ctrl       <= PLR_CTRL_RST;
      point_size <= PLR_PSIZE_RST;
      line_width <= PLR_LWIDTH_RST;
      fade_thr   <= PLR_FTHR_RST;
    end
    else if (wb_wr && !reject)
    begin
      case (wb_adr_i)
        PLR_REG_CTRL:
          ctrl <= merge(ctrl, wb_dat_i, wb_sel_i) & PLR_CTRL_MASK;
        PLR_REG_PSIZE:  point_size <= m_ps[15:0];
        PLR_REG_LWIDTH: line_width <= m_lw[15:0];
        PLR_REG_FTHR:   fade_thr <= m_ft[15:0];
        default: ;
      endcase
    end

  // Set beats clear
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      err <= 1'b0;
    else if (reject)
      err <= 1'b1;
    else if (err_clr)
      err <= 1'b0;

  // ------------------------------------------------------------
  // Point setup and per-pixel values
  // ------------------------------------------------------------
  plr_q_t      dsize;
  logic        fade_on;
  plr_q_t      wn;
  logic [31:0] fq;
  logic [31:0] fsq;
  logic [PLR_SAMPLES-1:0] pcov;
  plr_frag_s   pf;

  always_comb
  begin
    dsize = ctrl[PLR_CTRL_PROG] ? snap(pr.shader_size_output)
                                : snap(point_size);
    fade_on = ctrl[PLR_CTRL_MS] && ctrl[PLR_CTRL_FADE] &&
              dsize < fade_thr;
    wn = fade_on ? fade_thr : dsize;
    fq = (32'(dsize) << 8) /
         (fade_thr == 0 ? 32'h1 : 32'(fade_thr));
    fsq = (fq * fq) >> 8;
    pcov = samp_cov(cx, cy, pr.xa, pr.ya, w, ctrl[PLR_CTRL_MS]);
    pf = '0;
    pf.x = cx;
    pf.y = cy;
    pf.z = pr.za;
    pf.attr = pr.fa;
    pf.s = sprite(cx, pr.xa, w, 1'b0);
    pf.t = sprite(cy, pr.ya, w, ctrl[PLR_CTRL_ORIGIN]);
    pf.r = 16'sh0000;
    pf.q = PLR_ST_ONE;
    pf.cov = pcov;
    pf.fade = fade;
  end

  // ------------------------------------------------------------
  // Line setup and per-column values
  // ------------------------------------------------------------
  plr_q_t             dx;
  plr_q_t             dy;
  logic               xmaj;
  logic               pos;
  plr_q_t             ma;
  plr_q_t             mb;
  plr_q_t             na;
  plr_q_t             nb;
  plr_q_t             ks;
  plr_q_t             ke;
  logic signed [39:0] nn;
  plr_q_t             npx;
  plr_q_t             fx;
  plr_q_t             fy;
  logic signed [63:0] dot;
  logic signed [63:0] len;
  logic signed [63:0] tq;
  logic [12:0]        lt;
  plr_frag_s          lf;

  always_comb
  begin
    dx = pr.xb - pr.xa;
    dy = pr.yb - pr.ya;
    xmaj = (dy < 0 ? -dy : dy) <= (dx < 0 ? -dx : dx);
    ma = xmaj ? pr.xa : pr.ya;
    mb = xmaj ? pr.xb : pr.yb;
    na = xmaj ? pr.ya : pr.xa;
    nb = xmaj ? pr.yb : pr.xb;
    pos = mb > ma;
    // Centers in [ma,mb) going up, (mb,ma] going down
    ks = pos ? (ma + 16'sh0007) >>> 4
             : (ma - 16'sh0008) >>> 4;
    ke = pos ? (mb + 16'sh0007) >>> 4
             : (mb - 16'sh0008) >>> 4;
    nn = 40'(na) + ((40'(to_q(c, PLR_CENTER)) - 40'(ma)) *
         (40'(nb) - 40'(na))) /
         (mb == ma ? 40'sh1 : 40'(mb) - 40'(ma));
    npx = plr_q_t'(nn >>> 4);
    fx = xmaj ? c : npx;
    fy = xmaj ? npx : c;
    dot = (64'(to_q(fx, PLR_CENTER)) - 64'(pr.xa)) * 64'(dx) +
          (64'(to_q(fy, PLR_CENTER)) - 64'(pr.ya)) * 64'(dy);
    len = 64'(dx) * 64'(dx) + 64'(dy) * 64'(dy);
    tq = (dot <<< PLR_TSH) / (len == 0 ? 64'sh1 : len);
    if (tq < 0)
      lt = 13'h0000;
    else if (tq > 64'(PLR_T_ONE))
      lt = PLR_T_ONE;
    else
      lt = tq[12:0];
    lf = '0;
    lf.x = fx;
    lf.y = fy;
    lf.z = interp(PLR_MODE_NOPERSP, 32'(pr.za), 32'(pr.zb),
                  32'sh1, 32'sh1, lt);
    for (int i = 0; i < PLR_NATTR; i++)
      lf.attr[16*i +: 16] = interp(
        ctrl[PLR_CTRL_MODE + 2*i +: 2],
        32'($signed(pr.fa[16*i +: 16])),
        32'($signed(pr.fb[16*i +: 16])),
        32'(pr.wa), 32'(pr.wb), lt);
    lf.q = PLR_ST_ONE;
    lf.cov = {PLR_SAMPLES{1'b1}};
    lf.fade = PLR_FADE_1;
    lf.is_line = 1'b1;
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  logic ofree;
  logic emit;

  assign ofree = !frag_valid || frag_ready;
  assign emit  = ofree && ((st == ST_POINT && pcov != '0) ||
                           st == ST_LINE);

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      prim_ready <= 1'b1;
    else
      prim_ready <= st == ST_IDLE && !(prim_valid && prim_ready);

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      st   <= ST_IDLE;
      pr   <= '0;
      w    <= PLR_SIZE_ONE;
      fade <= PLR_FADE_1;
      bx0  <= '0;
      bx1  <= '0;
      by1  <= '0;
      cx   <= '0;
      cy   <= '0;
      c    <= '0;
      ce   <= '0;
    end
    else
    begin
      unique case (st)
        ST_IDLE:
          if (prim_valid && prim_ready)
          begin
            pr <= prim;
            st <= ST_SETUP;
          end
        ST_SETUP:
        begin
          w    <= wn;
          fade <= fade_on ? fsq[8:0] : PLR_FADE_1;
          bx0  <= ((pr.xa - (wn >>> 1)) >>> 4) - 16'sh0001;
          bx1  <= ((pr.xa + (wn >>> 1)) >>> 4) + 16'sh0001;
          by1  <= ((pr.ya + (wn >>> 1)) >>> 4) + 16'sh0001;
          cx   <= ((pr.xa - (wn >>> 1)) >>> 4) - 16'sh0001;
          cy   <= ((pr.ya - (wn >>> 1)) >>> 4) - 16'sh0001;
          c    <= ks;
          ce   <= ke;
          if (!pr.is_line)
            st <= ST_POINT;
          else if (ks == ke)
            st <= ST_IDLE;
          else
            st <= ST_LINE;
        end
        ST_POINT:
          if (ofree)
          begin
            if (cx != bx1)
              cx <= cx + 16'sh0001;
            else
            begin
              cx <= bx0;
              cy <= cy + 16'sh0001;
              if (cy == by1)
                st <= ST_IDLE;
            end
          end
        ST_LINE:
          if (ofree)
          begin
            c <= pos ? c + 16'sh0001 : c - 16'sh0001;
            if ((pos ? c + 16'sh0001 : c - 16'sh0001) == ce)
              st <= ST_IDLE;
          end
      endcase
    end

  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      frag_valid <= 1'b0;
      frag       <= '0;
      frag_cnt   <= 16'h0000;
    end
    else if (emit)
    begin
      frag_valid <= 1'b1;
      frag       <= st == ST_LINE ? lf : pf;
      frag_cnt   <= frag_cnt + 16'h0001;
    end
    else if (frag_ready)
      frag_valid <= 1'b0;
endmodule // plr_top

/* File: dv/plr_top_properties.sv */
`timescale 1ns/100ps
module plr_top_properties (
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic [31:0]        wb_dat_o,
  input wire logic               wb_ack_o,
  input wire logic               prim_valid,
  input wire logic               prim_ready,
  input wire plr_pkg::plr_prim_s prim,
  input wire logic               frag_valid,
  input wire logic               frag_ready,
  input wire plr_pkg::plr_frag_s frag
);
  import plr_pkg::*;
  logic [15:0]       pz;
  logic [PLR_AW-1:0] pfa;
  // ----------------------------------
  // Vertex data of the primitive taken
  // ----------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pz  <= '0;
      pfa <= '0;
    end
    else if (prim_valid && prim_ready)
    begin
      pz  <= prim.za;
      pfa <= prim.fa;
    end
  end
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  AST_ACK_NEXT:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  AST_ACK_PULSE:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_IDLE:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack cycle");
  AST_PRIM_TAKE:
    assert property (prim_valid && prim_ready |=> !prim_ready)
    else $error("ready stayed high after primitive taken");
  AST_FRAG_HOLD:
    assert property (frag_valid && !frag_ready |=>
      frag_valid && $stable(frag))
    else $error("fragment changed while stalled");
  AST_POINT_DATA:
    assert property (frag_valid && !frag.is_line |->
      frag.z == pz && frag.attr == pfa)
    else $error("point fragment data differs from vertex");
  AST_SPRITE_RQ:
    assert property (frag_valid && !frag.is_line |->
      frag.r == 16'sh0 && frag.q == PLR_ST_ONE)
    else $error("sprite r or q not constant");
  AST_LINE_COV:
    assert property (frag_valid && frag.is_line |-> frag.cov == 4'hf)
    else $error("line fragment not fully covered");
  AST_STEP:
    assert property (frag_valid && frag_ready |=> !frag_valid ||
      frag.x != $past(frag.x) || frag.y != $past(frag.y))
    else $error("same pixel emitted twice in a row");
  CV_POINT: cover property (frag_valid && frag_ready && !frag.is_line);
  CV_LINE: cover property (frag_valid && frag_ready && frag.is_line);
  CV_PART: cover property (frag_valid && frag.cov != 4'hf);
endmodule // plr_top_properties

bind plr_top plr_top_properties chk_u (
  .core_clk   (core_clk),
  .rst_n      (rst_n),
  .wb_cyc_i   (wb_cyc_i),
  .wb_stb_i   (wb_stb_i),
  .wb_dat_o   (wb_dat_o),
  .wb_ack_o   (wb_ack_o),
  .prim_valid (prim_valid),
  .prim_ready (prim_ready),
  .prim       (prim),
  .frag_valid (frag_valid),
  .frag_ready (frag_ready),
  .frag       (frag)
);

/* File: dv/plr_stream_model.sv */
`timescale 1ns/100ps
module plr_stream_model (
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic               stall,
  output      logic               prim_valid,
  input  wire logic               prim_ready,
  output      plr_pkg::plr_prim_s prim,
  input  wire logic               frag_valid,
  output      logic               frag_ready,
  input  wire plr_pkg::plr_frag_s frag
);
  import plr_pkg::*;
  int        nfrag = 0;
  int        nbase = 0;
  plr_frag_s first;
  plr_frag_s last;
  initial
  begin
    prim_valid = 1'b0;
    prim       = '0;
  end
  // Slow sink accepts every other cycle
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      frag_ready <= 1'b0;
    else
      frag_ready <= stall ? !frag_ready : 1'b1;
  end
  always @(posedge core_clk)
  begin
    if (frag_valid && frag_ready)
    begin
      if (nfrag == nbase)
        first <= frag;
      last  <= frag;
      nfrag <= nfrag + 1;
    end
  end
  // Offer, hold until taken, then wait for the drain
  task automatic send(input plr_prim_s p);
    int w;
    nbase = nfrag;
    prim_valid <= 1'b1;
    prim       <= p;
    do
      @(posedge core_clk);
    while (!prim_ready);
    prim_valid <= 1'b0;
    prim       <= ~p;
    w = 0;
    do
    begin
      @(posedge core_clk);
      w++;
    end
    while ((!prim_ready || frag_valid) && w < 2000);
    repeat (2) @(posedge core_clk);
  endtask
endmodule // plr_stream_model

/* File: dv/plr_top_tb_top.sv */
`timescale 1ns/100ps
module plr_top_tb_top;
  import plr_pkg::*;
  typedef struct packed {
    logic [11:0] ctrl;
    logic [7:0]  psz;
    logic [3:0]  lin;
    logic [7:0]  xa, ya, xb, yb;
    logic [3:0]  n, fx, fy;
    logic [11:0] s, t;
    logic [3:0]  cov;
    logic [11:0] fade;
  } plr_row_s;
  logic        core_clk;
  logic        rst_n;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [3:0]  wb_sel_i;
  logic        wb_we_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        prim_valid;
  logic        prim_ready;
  plr_prim_s   prim;
  logic        frag_valid;
  logic        frag_ready;
  plr_frag_s   frag;
  logic        stall;
  logic [31:0] rdq;
  int          n_mismatch = 0;
  int          compares = 0;
  logic [7:0]  bad_a [3] = '{PLR_REG_PSIZE, PLR_REG_LWIDTH, PLR_REG_FTHR};
  logic [31:0] bad_d [3] = '{32'h0, 32'h8000, 32'hfff0};
  plr_row_s    rows [11] = '{
    108'h004_10_0_a8a8_0000_1aa_080_080_f_100,
    108'h004_20_0_a0a0_0000_499_040_0c0_f_100,
    108'h000_20_0_a0a0_0000_499_040_040_f_100,
    108'h004_2f_0_a0a0_0000_988_000_100_f_100,
    108'h005_10_0_a0a0_0000_499_040_0c0_f_100,
    108'h006_10_0_a0a0_0000_499_000_100_8_100,
    108'h00e_08_0_a8a8_0000_1aa_080_080_f_040,
    108'h004_10_1_2838_6838_423_000_000_f_100,
    108'h004_10_1_6838_9838_363_000_000_f_100,
    108'h004_10_1_3828_3868_432_000_000_f_100,
    108'h604_10_1_2838_6838_423_000_000_f_100
  };
  plr_top dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .prim_valid(prim_valid),
    .prim_ready(prim_ready), .prim(prim), .frag_valid(frag_valid),
    .frag_ready(frag_ready), .frag(frag)
  );
  plr_stream_model model_u (
    .core_clk(core_clk), .rst_n(rst_n), .stall(stall),
    .prim_valid(prim_valid), .prim_ready(prim_ready), .prim(prim),
    .frag_valid(frag_valid), .frag_ready(frag_ready), .frag(frag)
  );
  always #50 core_clk = ~core_clk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic we,
                    input logic [31:0] d, output logic [31:0] q);
    wb_adr_i <= a;
    wb_we_i  <= we;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do
      @(posedge core_clk);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    wb(a, 1'b0, 32'h0, v);
    check(v, e);
  endtask
  task automatic run(input plr_row_s r);
    plr_prim_s   p;
    logic [31:0] q;
    wb(PLR_REG_CTRL, 1'b1, {20'h0, r.ctrl}, q);
    wb(PLR_REG_PSIZE, 1'b1, {24'h0, r.psz}, q);
    p = '0;
    p.is_line = r.lin[0];
    p.xa = {8'h0, r.xa};
    p.ya = {8'h0, r.ya};
    p.xb = {8'h0, r.xb};
    p.yb = {8'h0, r.yb};
    p.za = 16'h1234;
    p.zb = 16'h4321;
    p.wa = 16'h10;
    p.wb = 16'h20;
    p.fa = 32'h0003_0005;
    p.fb = 32'h0007_0009;
    p.shader_size_output = 16'sh20;
    model_u.send(p);
    check(model_u.nfrag - model_u.nbase, {28'h0, r.n});
    check(model_u.first.x, {28'h0, r.fx});
    check(model_u.first.y, {28'h0, r.fy});
    check(model_u.first.s, {20'h0, r.s});
    check(model_u.first.t, {20'h0, r.t});
    check(model_u.first.cov, {28'h0, r.cov});
    check(model_u.first.z, 32'h1234);
    check(model_u.first.attr, {16'h3, r.ctrl[9] ? 16'h9 : 16'h5});
    if (!r.lin[0])
      check(model_u.first.fade, {20'h0, r.fade});
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Whole run needs under a thousand cycles; the limit allows 30,000
  initial
  begin
    #3_000_000;
    n_mismatch++;
    complete_run;
  end
  initial
  begin
    core_clk = 1'b0;
    rst_n    = 1'b0;
    wb_adr_i = 8'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hf;
    wb_we_i  = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    stall    = 1'b0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    foreach (rows[i])
      run(rows[i]);
    // Last column of the modes row: flat and linear attributes
    check(model_u.last.attr, 32'h0006_0009);
    run(rows[7]);
    check(model_u.last.attr, 32'h0005_0007);
    rst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(PLR_REG_CTRL, 32'h4);
    rd(PLR_REG_PSIZE, 32'h10);
    rd(PLR_REG_LWIDTH, 32'h10);
    rd(PLR_REG_FTHR, 32'h10);
    rd(PLR_REG_ERR, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      wb(bad_a[i], 1'b1, bad_d[i], rdq);
      rd(bad_a[i], 32'h10);
      rd(PLR_REG_ERR, 32'h1);
      wb(PLR_REG_ERR, 1'b1, 32'h1, rdq);
    end
    rd(PLR_REG_ERR, 32'h0);
    wb(PLR_REG_LWIDTH, 1'b1, 32'h20, rdq);
    rd(PLR_REG_LWIDTH, 32'h20);
    wb(8'h20, 1'b1, 32'h5, rdq);
    rd(8'h20, 32'h0);
    stall <= 1'b1;
    run(rows[1]);
    rd(PLR_REG_STATUS, 32'h0004_0000);
    complete_run;
  end
endmodule // plr_top_tb_top
